// *** hw/edge_sync.sv ***
`timescale 1ns/1ps
module edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } st_s;
  st_s st_q, st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) st_q <= '0;
    else st_q <= st_d;
  end
  assign level = st_q.s2;
  assign rise  = st_q.s2 & ~st_q.s3;
  assign fall  = ~st_q.s2 & st_q.s3;
endmodule : edge_sync

// *** hw/timer16_capture_compare.sv ***
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_capture_compare import timer16_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        countTick,
  input  wire logic        firstEdgeInput,
  input  wire logic        sharedPortPinIn,
  input  wire bus_req_s    busReq,
  output logic      [15:0] rdata,
  output logic             firstMatchIrq,
  output logic             secondMatchIrq,
  output logic             timerOutput,
  output logic             timerOutputEn
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cc0;
    logic [15:0] cc1;
    logic [7:0]  mode;
    logic        ovf;
    logic [15:0] rdata;
    logic        irq0;
    logic        irq1;
    logic        pendIrq0;
    logic        pendIrq1;
    logic        held;
    logic        tout;
    logic        toutEn;
    logic        clearNext;
  } st_s;
  st_s st_q, st_d;
  logic e0Lvl, e0Rise, e0Fall;
  logic e1Lvl, e1Rise, e1Fall;
  logic [1:0] runBits;
  run_e runMode;
  logic running, tick, capTrig0, capTrig1, wrap, readCnt;

  edge_sync u_sync0 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (firstEdgeInput),
    .level   (e0Lvl),
    .rise    (e0Rise),
    .fall    (e0Fall)
  );
  edge_sync u_sync1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (sharedPortPinIn),
    .level   (e1Lvl),
    .rise    (e1Rise),
    .fall    (e1Fall)
  );

  always_comb begin
    runBits  = {st_q.mode[`MODE_RUN_HI], st_q.mode[`MODE_RUN_LO]};
    runMode  = run_e'(runBits);
    running  = (runMode != RUN_STOP);
    readCnt  = busReq.rd && (busReq.addr == `ADDR_COUNTER);
    // Tick that lands during a read is held until the first cycle without a read, not dropped
    tick     = running && (countTick || st_q.held) && !readCnt;
    // Capture on the synchronized rise of the edge input: sample without waiting for a tick
    capTrig0 = running && e0Rise;
    capTrig1 = running && e1Rise && !st_q.mode[`MODE_PIN_OUT];
    wrap     = (st_q.cnt == `MAX_COUNT);
  end

  always_comb begin
    st_d      = st_q;
    st_d.irq0 = 1'b0;
    st_d.irq1 = 1'b0;
    // One pending bit only: ticks and counter reads must not pile up back to back
    st_d.held = running && (readCnt ? (countTick || st_q.held)
                                    : (countTick && st_q.held));
    if (running && (st_q.pendIrq0 || st_q.pendIrq1) && tick) begin
      st_d.irq0     = st_q.pendIrq0;
      st_d.irq1     = st_q.pendIrq1;
      st_d.pendIrq0 = 1'b0;
      st_d.pendIrq1 = 1'b0;
    end
    if (!running) begin
      st_d.cnt       = 16'h0000;
      st_d.clearNext = 1'b0;
      st_d.pendIrq0  = 1'b0;
      st_d.pendIrq1  = 1'b0;
    end else if (tick) begin
      if (st_q.clearNext || (runMode == RUN_EDGE_CLEAR && e0Rise)) begin
        st_d.cnt = 16'h0000;
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
      st_d.clearNext = 1'b0;
      if (wrap) st_d.ovf = 1'b1;
      // Match is seen on the stepped value, so zero fires on 0 to 1 after wrap
      if (!st_q.mode[`MODE_CC0_CAP] && st_d.cnt == st_q.cc0
          && st_d.cnt != 16'h0000) begin
        st_d.irq0 = 1'b1;
        if (runMode == RUN_MATCH_CLEAR) st_d.clearNext = 1'b1;
        st_d.tout = ~st_q.tout;
      end
      if (!st_q.mode[`MODE_CC0_CAP] && st_q.cc0 == 16'h0000 && st_q.cnt == 16'h0000
          && st_d.cnt == 16'h0001 && runMode != RUN_MATCH_CLEAR) begin
        st_d.irq0 = 1'b1;
      end
      if (!st_q.mode[`MODE_CC1_CAP] && st_d.cnt == st_q.cc1) st_d.irq1 = 1'b1;
    end
    // Only edge triggers capture; a counter read never reaches this path
    if (capTrig0 && st_q.mode[`MODE_CC0_CAP]) begin
      st_d.cc0      = st_q.cnt;
      st_d.pendIrq0 = 1'b1;
    end
    if (capTrig1 && st_q.mode[`MODE_CC1_CAP]) begin
      st_d.cc1      = st_q.cnt;
      st_d.pendIrq1 = 1'b1;
    end
    st_d.toutEn = st_q.mode[`MODE_PIN_OUT];
    if (busReq.wr) begin
      case (busReq.addr)
        `ADDR_CC0:  st_d.cc0 = busReq.wdata;
        `ADDR_CC1:  st_d.cc1 = busReq.wdata;
        `ADDR_MODE: begin
          st_d.mode = busReq.wdata[7:0];
          // Overflow flag only clears; a wrap in this cycle still wins
          if (!busReq.wdata[`MODE_OVF] && !(tick && wrap)) st_d.ovf = 1'b0;
        end
        default: ;
      endcase
    end
    st_d.rdata = 16'h0000;
    if (busReq.rd) begin
      case (busReq.addr)
        `ADDR_COUNTER: st_d.rdata = st_q.cnt;
        `ADDR_CC0:     st_d.rdata = st_q.cc0;
        `ADDR_CC1:     st_d.rdata = st_q.cc1;
        `ADDR_MODE:    st_d.rdata = {8'h00, st_q.mode[7:3], st_q.ovf, st_q.mode[1:0]};
        `ADDR_STATUS:  st_d.rdata = {13'h0000, e1Lvl, e0Lvl, running};
        default:       st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.mode <= `MODE_RESET;
      st_q.cc0  <= `CC_RESET;
      st_q.cc1  <= `CC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata          = st_q.rdata;
  assign firstMatchIrq  = st_q.irq0;
  assign secondMatchIrq = st_q.irq1;
  assign timerOutput    = st_q.tout;
  assign timerOutputEn  = st_q.toutEn;

  property p_stop_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !running |=> (st_q.cnt == 16'h0000);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Counter not zero when stopped");

  property p_read_no_cap;
    @(posedge ref_clk) disable iff (!rst_n)
      (readCnt && !capTrig1 && !busReq.wr) |=> $stable(st_q.cc1);
  endproperty
  a_read_no_cap: assert property (p_read_no_cap) else $error("Read loaded capture reg");

  property p_held_tick;
    @(posedge ref_clk) disable iff (!rst_n)
      (running && countTick && readCnt && !st_q.held) |=> st_q.held;
  endproperty
  a_held_tick: assert property (p_held_tick) else $error("Tick lost on read");

  property p_ovf;
    @(posedge ref_clk) disable iff (!rst_n)
      (tick && wrap) |=> st_q.ovf && st_q.cnt == 16'h0000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("Overflow flag missed");

  property p_clear_match;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q.clearNext && tick && running) |=> st_q.cnt == 16'h0000;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("No clear on match");

  property p_cap_compare;
    @(posedge ref_clk) disable iff (!rst_n)
      (!st_q.mode[`MODE_CC0_CAP] && !busReq.wr) |=> $stable(st_q.cc0);
  endproperty
  a_cap_compare: assert property (p_cap_compare) else $error("Compare reg captured");

  property p_cap_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q.pendIrq1 && running && tick) |=> secondMatchIrq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("Capture request not raised");

  property p_zero_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
      (running && runMode != RUN_MATCH_CLEAR && !st_q.mode[`MODE_CC0_CAP]
       && st_q.cc0 == 16'h0000 && st_q.cnt == 16'h0000 && tick && !st_q.clearNext
       && !(runMode == RUN_EDGE_CLEAR && e0Rise)) |=> firstMatchIrq;
  endproperty
  a_zero_wrap: assert property (p_zero_wrap) else $error("Zero compare match missed");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !busReq.rd |=> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not idle");

  property p_rdata_cnt;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.rd && busReq.addr == `ADDR_COUNTER) |=> rdata == $past(st_q.cnt);
  endproperty
  a_rdata_cnt: assert property (p_rdata_cnt) else $error("Counter read wrong");

  property p_rdata_cc0;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.rd && busReq.addr == `ADDR_CC0) |=> rdata == $past(st_q.cc0);
  endproperty
  a_rdata_cc0: assert property (p_rdata_cc0) else $error("First register read wrong");

  property p_rdata_cc1;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.rd && busReq.addr == `ADDR_CC1) |=> rdata == $past(st_q.cc1);
  endproperty
  a_rdata_cc1: assert property (p_rdata_cc1) else $error("Second register read wrong");

  property p_rdata_unmapped;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.rd && busReq.addr > `ADDR_STATUS) |=> rdata == 16'h0000;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("Unmapped read not zero");

  property p_wr_cc1;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.wr && busReq.addr == `ADDR_CC1) |=> st_q.cc1 == $past(busReq.wdata);
  endproperty
  a_wr_cc1: assert property (p_wr_cc1) else $error("Second register write lost");

  property p_wr_mode;
    @(posedge ref_clk) disable iff (!rst_n)
      (busReq.wr && busReq.addr == `ADDR_MODE) |=> st_q.mode == $past(busReq.wdata[7:0]);
  endproperty
  a_wr_mode: assert property (p_wr_mode) else $error("Mode write lost");

  property p_stop_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      !running |=> !firstMatchIrq && !secondMatchIrq;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("Request while stopped");

  property p_read_freeze;
    @(posedge ref_clk) disable iff (!rst_n)
      (running && readCnt) |=> $stable(st_q.cnt);
  endproperty
  a_read_freeze: assert property (p_read_freeze) else $error("Count moved during read");

  property p_held_count;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q.held && running && !readCnt && runMode != RUN_EDGE_CLEAR) |=> !$stable(st_q.cnt);
  endproperty
  a_held_count: assert property (p_held_count) else $error("Held tick not applied");

  property p_ovf_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q.ovf && !(busReq.wr && busReq.addr == `ADDR_MODE)) |=> st_q.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow flag dropped");

  property p_ovf_only_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
      (!st_q.ovf && !(tick && wrap)) |=> !st_q.ovf;
  endproperty
  a_ovf_only_wrap: assert property (p_ovf_only_wrap) else $error("Overflow without wrap");

  property p_cap1_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (capTrig1 && st_q.mode[`MODE_CC1_CAP] && !busReq.wr) |=> st_q.cc1 == $past(st_q.cnt);
  endproperty
  a_cap1_load: assert property (p_cap1_load) else $error("Second capture wrong");

  property p_cap0_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (capTrig0 && st_q.mode[`MODE_CC0_CAP] && !busReq.wr) |=> st_q.cc0 == $past(st_q.cnt);
  endproperty
  a_cap0_load: assert property (p_cap0_load) else $error("First capture wrong");

  property p_pin_out;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q.mode[`MODE_PIN_OUT] |=> timerOutputEn;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("Output enable missing");

  property p_pin_no_cap;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q.mode[`MODE_PIN_OUT] && !busReq.wr) |=> $stable(st_q.cc1);
  endproperty
  a_pin_no_cap: assert property (p_pin_no_cap) else $error("Output pin captured");

  property p_match_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (running && tick && !st_q.mode[`MODE_CC0_CAP] && st_q.cc0 != 16'h0000
       && st_q.cnt == st_q.cc0 - 16'h0001 && !st_q.clearNext
       && !(runMode == RUN_EDGE_CLEAR && e0Rise)) |=> firstMatchIrq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("Match request missed");

  property p_match_clear_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (running && tick && runMode == RUN_MATCH_CLEAR && !st_q.mode[`MODE_CC0_CAP]
       && st_q.cc0 != 16'h0000 && st_q.cnt == st_q.cc0 - 16'h0001
       && !st_q.clearNext) |=> st_q.clearNext;
  endproperty
  a_match_clear_set: assert property (p_match_clear_set) else $error("Clear not armed");
endmodule : timer16_capture_compare

// *** hw/timer16_pkg.sv ***
package timer16_pkg;
  typedef enum logic [1:0] {RUN_STOP, RUN_FREE, RUN_EDGE_CLEAR, RUN_MATCH_CLEAR} run_e;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;
endpackage : timer16_pkg

// *** hw/timer16_regs.svh ***
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH
// Function
// - A software read of the up-counter never loads the second capture/compare register.
// - A counter read briefly holds the count clock; one tick is kept pending, and a second pending tick is lost.
// - With first compare zero in free-run or edge-clear mode, the match fires on the step 0 to 1.
// - A compare value below the count is reached only after overflow and restart from zero.
// - A first capture/compare register in compare mode is not loaded by a capture trigger.
// - The counter runs whenever the two run-mode bits are not both zero.
// - With first compare at ffff the overflow flag sets on the step from ffff to 0000.
// - Captures happen on a synchronized edge-input rise; their request follows on the next count tick.
`define ADDR_COUNTER   4'h0
`define ADDR_CC0       4'h1
`define ADDR_CC1       4'h2
`define ADDR_MODE      4'h3
`define ADDR_STATUS    4'h4
`define MODE_RUN_LO    0
`define MODE_RUN_HI    1
`define MODE_OVF       2
`define MODE_CC0_CAP   3
`define MODE_CC1_CAP   4
`define MODE_PIN_OUT   5
`define MODE_RESET     8'h00
`define CC_RESET       16'h0000
`define MAX_COUNT      16'hffff
`endif

// *** verif/timer16_capture_compare_tb.sv ***
`timescale 1ns/1ps
`include "timer16_regs.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module timer16_capture_compare_tb import timer16_pkg::*; ;
  logic        ref_clk = 0;
  logic        rst_n = 0;
  logic        countTick = 0;
  logic        firstEdgeInput = 0;
  logic        sharedPortPinIn = 0;
  bus_req_s    busReq = '0;
  logic [15:0] rdata;
  logic        firstMatchIrq;
  logic        secondMatchIrq;
  int          irq1Seen = 0;
  int          toutModel = 0;
  logic        timerOutput;
  logic        timerOutputEn;
  int          errors = 0;
  int          tests_run = 0;
  int          irqSeen = 0;
  int          irqModel = 0;
  int          cnt = 0;
  int          cc0 = 0;
  int          runMode = 0;
  logic [31:0] seed = 32'h13;
  logic [15:0] got;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (firstMatchIrq === 1'b1) irqSeen++;
  always @(posedge ref_clk) if (secondMatchIrq === 1'b1) irq1Seen++;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift

  timer16_capture_compare timer16_capture_compare_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .countTick(countTick),
    .firstEdgeInput(firstEdgeInput), .sharedPortPinIn(sharedPortPinIn),
    .busReq(busReq), .rdata(rdata), .firstMatchIrq(firstMatchIrq),
    .secondMatchIrq(secondMatchIrq), .timerOutput(timerOutput),
    .timerOutputEn(timerOutputEn));

  task final_report;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // Model of n count clock ticks; match-clear zeroes on the tick after the match
  task ticks(input int n);
    int prev;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      countTick <= 1'b1;
      prev = cnt;
      if (runMode == 3 && cc0 != 0 && cnt == cc0) cnt = 0;
      else if (runMode != 0) cnt = (cnt + 1) & 'hffff;
      if (runMode != 0 && cc0 != 0 && cnt == cc0) begin
        irqModel++;
        toutModel++;
      end
      if (runMode != 0 && runMode != 3 && cc0 == 0 && prev == 0 && cnt == 1) irqModel++;
    end
    @(posedge ref_clk);
    countTick <= 1'b0;
  endtask : ticks

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
    if (a == `ADDR_MODE) runMode = d[1:0];
    if (a == `ADDR_MODE && d[1:0] == 2'b00) cnt = 0;
    if (a == `ADDR_CC0) cc0 = d;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd

  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`ADDR_MODE);
    `CHK("mode", 16'h0000, got)
    wr(`ADDR_MODE, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      ticks(seed % 40 + 1);
      rd(`ADDR_COUNTER);
      `CHK("count", cnt[15:0], got)
    end
    // A tick on the very cycle of a counter read must still be counted
    @(posedge ref_clk);
    countTick <= 1'b1;
    busReq <= '{addr: `ADDR_COUNTER, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    countTick <= 1'b0;
    busReq.rd <= 1'b0;
    cnt++;
    repeat (2) @(posedge ref_clk);
    rd(`ADDR_COUNTER);
    `CHK("count after read", cnt[15:0], got)
    wr(`ADDR_MODE, 16'h0000);
    wr(`ADDR_MODE, 16'h0011);
    ticks(7);
    repeat (3) rd(`ADDR_COUNTER);
    rd(`ADDR_CC1);
    `CHK("cc1", 16'h0000, got)
    @(posedge ref_clk);
    sharedPortPinIn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sharedPortPinIn <= 1'b0;
    rd(`ADDR_CC1);
    `CHK("cc1 capture", cnt[15:0], got)
    ticks(1);
    repeat (2) @(posedge ref_clk);
    `CHK("capture irq", 1, irq1Seen)
    wr(`ADDR_MODE, 16'h0000);
    wr(`ADDR_CC0, 16'h0005);
    wr(`ADDR_MODE, 16'h0001);
    firstEdgeInput <= 1'b1;
    repeat (4) @(posedge ref_clk);
    firstEdgeInput <= 1'b0;
    rd(`ADDR_CC0);
    `CHK("cc0", 16'h0005, got)
    wr(`ADDR_MODE, 16'h0000);
    wr(`ADDR_CC0, 16'h0020);
    wr(`ADDR_MODE, 16'h0003);
    ticks(8'h21 * 2 + 3);
    rd(`ADDR_COUNTER);
    `CHK("clear count", cnt[15:0], got)
    // A compare value below the count is passed by, the counter keeps rising
    wr(`ADDR_CC0, 16'h0002);
    ticks(10);
    rd(`ADDR_COUNTER);
    `CHK("lowered cc0", cnt[15:0], got)
    wr(`ADDR_MODE, 16'h0000);
    wr(`ADDR_MODE, 16'h0003);
    repeat (3) @(posedge ref_clk);
    `CHK("irq count", irqModel, irqSeen)
    wr(`ADDR_MODE, 16'h0000);
    wr(`ADDR_CC0, 16'hffff);
    wr(`ADDR_MODE, 16'h0021);
    repeat (2) @(posedge ref_clk);
    `CHK("pin out", 1'b1, timerOutputEn)
    ticks(65536);
    rd(`ADDR_MODE);
    `CHK("overflow", 16'h0025, got)
    rd(`ADDR_COUNTER);
    `CHK("wrap count", cnt[15:0], got)
    repeat (3) @(posedge ref_clk);
    `CHK("irq wrap", irqModel, irqSeen)
    `CHK("timer out", toutModel[0], timerOutput)
    wr(`ADDR_MODE, 16'h0000);
    ticks(5);
    rd(`ADDR_COUNTER);
    `CHK("stopped", 16'h0000, got)
    final_report();
  end
endmodule : timer16_capture_compare_tb
